// File: hw/pin_mux_pkg.sv
package pin_mux_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] FIRST_LEVELS_OFS = 8'h00;
	localparam logic [7:0] FIRST_DIR_OFS = 8'h04;
	localparam logic [7:0] SECOND_LEVELS_OFS = 8'h08;
	localparam logic [7:0] SECOND_DIR_OFS = 8'h0C;
	localparam logic [7:0] FIRST_FUNC_LO_OFS = 8'h10;
	localparam logic [7:0] FIRST_FUNC_HI_OFS = 8'h14;
	localparam logic [7:0] SECOND_FUNC_OFS = 8'h18;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] DIR_RESET = 8'hFF;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [15:0] FUNC_RESET = 16'h0000;

	// ------------------------------------------------------------
	// Pin function selects, 3 bits per first-port pin
	// ------------------------------------------------------------
	localparam int FSEL_W = 3;
	localparam logic [2:0] FN_GPIO = 3'h0;
	localparam logic [2:0] FN_LCD = 3'h1;
	localparam logic [2:0] FN_TMR_IN = 3'h2;
	localparam logic [2:0] FN_PERIPH_A = 3'h3;
	localparam logic [2:0] FN_PERIPH_B = 3'h4;
	localparam logic [2:0] FN_PERIPH_C = 3'h5;
	localparam logic [2:0] FN_PERIPH_D = 3'h6;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: hw/axil_regs_slave.sv
`timescale 1ns/1ps
module axil_regs_slave (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [7:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [7:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	output logic wr_en_o,
	output logic [7:0] wr_addr_o,
	output logic [31:0] wr_data_o,
	output logic [3:0] wr_strb_o,
	input wire logic wr_ok_i,
	output logic [7:0] rd_addr_o,
	input wire logic [31:0] rd_data_i,
	input wire logic rd_ok_i
);
	import pin_mux_pkg::*;

	logic aw_have_r;
	logic w_have_r;
	logic aw_have_nxt;
	logic w_have_nxt;
	logic bvalid_nxt;
	logic rvalid_nxt;
	logic [7:0] aw_r;
	logic [31:0] wd_r;
	logic [3:0] ws_r;

	// ------------------------------------------------------------
	// Write channel: address and data in either order
	// ------------------------------------------------------------
	assign wr_en_o = aw_have_r && w_have_r && !bvalid_o;

	// Next flag state lets the readies leave from flops with no added cycle
	always_comb begin
		aw_have_nxt = aw_have_r;
		w_have_nxt = w_have_r;
		bvalid_nxt = bvalid_o;
		if (awvalid_i && awready_o)
			aw_have_nxt = 1'b1;
		if (wvalid_i && wready_o)
			w_have_nxt = 1'b1;
		if (wr_en_o) begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			bvalid_nxt = 1'b1;
		end else if (bvalid_o && bready_i) begin
			bvalid_nxt = 1'b0;
		end
	end
	assign wr_addr_o = aw_r;
	assign wr_data_o = wd_r;
	assign wr_strb_o = ws_r;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_r <= 8'h00;
			wd_r <= 32'h00000000;
			ws_r <= 4'h0;
			bvalid_o <= 1'b0;
			bresp_o <= RESP_OKAY;
		end else begin
			if (awvalid_i && awready_o) begin
				aw_have_r <= 1'b1;
				aw_r <= awaddr_i;
			end
			if (wvalid_i && wready_o) begin
				w_have_r <= 1'b1;
				wd_r <= wdata_i;
				ws_r <= wstrb_i;
			end
			if (wr_en_o) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				bvalid_o <= 1'b1;
				bresp_o <= wr_ok_i ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_o && bready_i) begin
				bvalid_o <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	assign rd_addr_o = araddr_i;

	always_comb begin
		rvalid_nxt = rvalid_o;
		if (arvalid_i && arready_o)
			rvalid_nxt = 1'b1;
		else if (rvalid_o && rready_i)
			rvalid_nxt = 1'b0;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rvalid_o <= 1'b0;
			rdata_o <= 32'h00000000;
			rresp_o <= RESP_OKAY;
		end else if (arvalid_i && arready_o) begin
			rvalid_o <= 1'b1;
			rdata_o <= rd_ok_i ? rd_data_i : 32'h00000000;
			rresp_o <= rd_ok_i ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_o && rready_i) begin
			rvalid_o <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Registered readies
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			awready_o <= 1'b1;
			wready_o <= 1'b1;
			arready_o <= 1'b1;
		end else begin
			awready_o <= !aw_have_nxt && !bvalid_nxt;
			wready_o <= !w_have_nxt && !bvalid_nxt;
			arready_o <= !rvalid_nxt;
		end
	end
endmodule // axil_regs_slave

// File: hw/pin_cell.sv
`timescale 1ns/1ps
module pin_cell (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic latch_i,
	input wire logic dir_in_i,
	input wire logic periph_en_i,
	input wire logic periph_out_i,
	input wire logic periph_oe_i,
	input wire logic pad_i,
	output logic pad_o,
	output logic pad_oe_o,
	output logic level_o
);
	// Registered drive keeps pad outputs glitch free
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pad_o <= 1'b0;
			pad_oe_o <= 1'b0;
			level_o <= 1'b0;
		end else begin
			pad_o <= periph_en_i ? periph_out_i : latch_i;
			pad_oe_o <= periph_en_i ? periph_oe_i : !dir_in_i;
			level_o <= pad_i;
		end
	end
endmodule // pin_cell

// File: hw/dual_port_io_pin_mux.sv
// Contract
// - The second port has eight pins, each with its own direction bit.
// - A direction bit of 1 makes a GPIO-mode second-port pin an input with its driver off.
// - A direction bit of 0 makes a GPIO-mode second-port pin drive its latch value.
// - Reading a pin-level register returns the level sampled on each pin.
// - Writing a port register updates the latch, which shows only on output pins.
// - First-port pins 0 to 2 are GPIO or LCD bias inputs.
// - First-port pin 3 is GPIO or an LCD segment output.
// - First-port pin 4 is GPIO, timer gate in, serial data out or LCD segment.
// - First-port pin 5 is GPIO, timer clock in, first capture/compare/PWM or LCD segment.
// - First-port pin 6 is GPIO, async transmit, sync clock, SPI clock, I2C clock or LCD segment.
// - First-port pin 7 is GPIO, async receive, sync data, SPI data in, I2C data or LCD segment.
// - Second-port pin 0 is GPIO or an LCD common output.
// - Second-port pin 1 is GPIO only.
// - Second-port pin 2 is GPIO or the second capture/compare/PWM.
// - Second-port pins 3 to 7 are GPIO or LCD segment outputs.
`timescale 1ns/1ps
module dual_port_io_pin_mux (
	input wire logic MCLK_I,
	input wire logic RSTN_I,
	input wire logic [7:0] S_AWADDR_I,
	input wire logic S_AWVALID_I,
	output logic S_AWREADY_O,
	input wire logic [31:0] S_WDATA_I,
	input wire logic [3:0] S_WSTRB_I,
	input wire logic S_WVALID_I,
	output logic S_WREADY_O,
	output logic [1:0] S_BRESP_O,
	output logic S_BVALID_O,
	input wire logic S_BREADY_I,
	input wire logic [7:0] S_ARADDR_I,
	input wire logic S_ARVALID_I,
	output logic S_ARREADY_O,
	output logic [31:0] S_RDATA_O,
	output logic [1:0] S_RRESP_O,
	output logic S_RVALID_O,
	input wire logic S_RREADY_I,
	input wire logic [7:0] FIRST_PAD_I,
	output logic [7:0] FIRST_PAD_O,
	output logic [7:0] FIRST_PAD_OE_O,
	input wire logic [7:0] SECOND_PAD_I,
	output logic [7:0] SECOND_PAD_O,
	output logic [7:0] SECOND_PAD_OE_O,
	output logic [2:0] LCD_BIAS_SEL_O,
	input wire logic [7:0] FIRST_PERIPH_OUT_I,
	input wire logic [7:0] FIRST_PERIPH_OE_I,
	output logic [7:0] FIRST_PERIPH_IN_O,
	input wire logic [7:0] SECOND_PERIPH_OUT_I,
	input wire logic [7:0] SECOND_PERIPH_OE_I,
	output logic [7:0] SECOND_PERIPH_IN_O
);
	import pin_mux_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0] first_latch_r;
	logic [7:0] first_dir_r;
	logic [7:0] second_latch_r;
	logic [7:0] second_dir_r;
	logic [23:0] first_fsel_r;
	logic [7:0] second_fsel_r;
	logic [7:0] first_level;
	logic [7:0] second_level;
	logic [7:0] first_pen;
	logic [7:0] second_pen;
	logic [7:0] first_pout;
	logic [7:0] first_poe;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_ok;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_ok;

	// Which select codes are legal for each first-port pin
	function automatic logic fsel_legal(input int pin, input logic [2:0] sel);
		logic ok;
		ok = (sel == FN_GPIO);
		case (pin)
			0, 1, 2: ok = ok || (sel == FN_LCD);
			3: ok = ok || (sel == FN_LCD);
			4: ok = ok || (sel == FN_LCD) || (sel == FN_TMR_IN) || (sel == FN_PERIPH_A);
			5: ok = ok || (sel == FN_LCD) || (sel == FN_TMR_IN) || (sel == FN_PERIPH_A);
			6, 7: ok = ok || (sel == FN_LCD) || ((sel >= FN_PERIPH_A) && (sel <= FN_PERIPH_D));
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	function automatic logic [7:0] byte_merge(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
		return s[0] ? d[7:0] : old;
	endfunction

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	axil_regs_slave u_bus (
		.clk_i(MCLK_I),
		.rstn_i(RSTN_I),
		.awaddr_i(S_AWADDR_I),
		.awvalid_i(S_AWVALID_I),
		.awready_o(S_AWREADY_O),
		.wdata_i(S_WDATA_I),
		.wstrb_i(S_WSTRB_I),
		.wvalid_i(S_WVALID_I),
		.wready_o(S_WREADY_O),
		.bresp_o(S_BRESP_O),
		.bvalid_o(S_BVALID_O),
		.bready_i(S_BREADY_I),
		.araddr_i(S_ARADDR_I),
		.arvalid_i(S_ARVALID_I),
		.arready_o(S_ARREADY_O),
		.rdata_o(S_RDATA_O),
		.rresp_o(S_RRESP_O),
		.rvalid_o(S_RVALID_O),
		.rready_i(S_RREADY_I),
		.wr_en_o(wr_en),
		.wr_addr_o(wr_addr),
		.wr_data_o(wr_data),
		.wr_strb_o(wr_strb),
		.wr_ok_i(wr_ok),
		.rd_addr_o(rd_addr),
		.rd_data_i(rd_data),
		.rd_ok_i(rd_ok)
	);

	always_comb begin
		case (wr_addr)
			FIRST_LEVELS_OFS, FIRST_DIR_OFS, SECOND_LEVELS_OFS, SECOND_DIR_OFS,
			FIRST_FUNC_LO_OFS, FIRST_FUNC_HI_OFS, SECOND_FUNC_OFS: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Port latches and direction
	// ------------------------------------------------------------
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			first_latch_r <= LATCH_RESET;
			second_latch_r <= LATCH_RESET;
		end else if (wr_en) begin
			if (wr_addr == FIRST_LEVELS_OFS)
				first_latch_r <= byte_merge(first_latch_r, wr_data, wr_strb);
			if (wr_addr == SECOND_LEVELS_OFS)
				second_latch_r <= byte_merge(second_latch_r, wr_data, wr_strb);
		end
	end

	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			first_dir_r <= DIR_RESET;
			second_dir_r <= DIR_RESET;
		end else if (wr_en) begin
			if (wr_addr == FIRST_DIR_OFS)
				first_dir_r <= byte_merge(first_dir_r, wr_data, wr_strb);
			if (wr_addr == SECOND_DIR_OFS)
				second_dir_r <= byte_merge(second_dir_r, wr_data, wr_strb);
		end
	end

	// ------------------------------------------------------------
	// Function selects
	// ------------------------------------------------------------
	// Illegal codes are dropped per pin so a pin never lands on a missing function
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			first_fsel_r <= {FUNC_RESET, 8'h00};
			second_fsel_r <= 8'h00;
		end else if (wr_en) begin
			for (int p = 0; p < 8; p++) begin
				if ((wr_addr == (p < 4 ? FIRST_FUNC_LO_OFS : FIRST_FUNC_HI_OFS)) && wr_strb[(p % 4) / 2]
						&& fsel_legal(p, wr_data[(p % 4) * 4 +: FSEL_W]))
					first_fsel_r[p * FSEL_W +: FSEL_W] <= wr_data[(p % 4) * 4 +: FSEL_W];
			end
			if ((wr_addr == SECOND_FUNC_OFS) && wr_strb[0])
				second_fsel_r <= wr_data[7:0] & 8'hFD;
		end
	end

	// ------------------------------------------------------------
	// Peripheral routing
	// ------------------------------------------------------------
	always_comb begin
		for (int p = 0; p < 8; p++) begin
			first_pen[p] = (first_fsel_r[p * FSEL_W +: FSEL_W] != FN_GPIO);
			first_pout[p] = FIRST_PERIPH_OUT_I[p];
			first_poe[p] = FIRST_PERIPH_OE_I[p];
		end
		// Analog bias inputs: digital driver must stay off
		for (int p = 0; p < 3; p++) begin
			first_pout[p] = 1'b0;
			first_poe[p] = 1'b0;
		end
		// Timer gate and clock are pure inputs
		if (first_fsel_r[4 * FSEL_W +: FSEL_W] == FN_TMR_IN) first_poe[4] = 1'b0;
		if (first_fsel_r[5 * FSEL_W +: FSEL_W] == FN_TMR_IN) first_poe[5] = 1'b0;
		second_pen = second_fsel_r;
	end

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_pins
			pin_cell u_first (
				.clk_i(MCLK_I),
				.rstn_i(RSTN_I),
				.latch_i(first_latch_r[g]),
				.dir_in_i(first_dir_r[g]),
				.periph_en_i(first_pen[g]),
				.periph_out_i(first_pout[g]),
				.periph_oe_i(first_poe[g]),
				.pad_i(FIRST_PAD_I[g]),
				.pad_o(FIRST_PAD_O[g]),
				.pad_oe_o(FIRST_PAD_OE_O[g]),
				.level_o(first_level[g])
			);
			pin_cell u_second (
				.clk_i(MCLK_I),
				.rstn_i(RSTN_I),
				.latch_i(second_latch_r[g]),
				.dir_in_i(second_dir_r[g]),
				.periph_en_i(second_pen[g]),
				.periph_out_i(SECOND_PERIPH_OUT_I[g]),
				.periph_oe_i(SECOND_PERIPH_OE_I[g]),
				.pad_i(SECOND_PAD_I[g]),
				.pad_o(SECOND_PAD_O[g]),
				.pad_oe_o(SECOND_PAD_OE_O[g]),
				.level_o(second_level[g])
			);
		end
	endgenerate

	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			FIRST_PERIPH_IN_O <= 8'h00;
			SECOND_PERIPH_IN_O <= 8'h00;
			LCD_BIAS_SEL_O <= 3'h0;
		end else begin
			FIRST_PERIPH_IN_O <= first_level & first_pen;
			SECOND_PERIPH_IN_O <= second_level & second_pen;
			LCD_BIAS_SEL_O <= first_pen[2:0];
		end
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	always_comb begin
		rd_ok = 1'b1;
		rd_data = 32'h00000000;
		case (rd_addr)
			FIRST_LEVELS_OFS: rd_data[7:0] = first_level;
			FIRST_DIR_OFS: rd_data[7:0] = first_dir_r;
			SECOND_LEVELS_OFS: rd_data[7:0] = second_level;
			SECOND_DIR_OFS: rd_data[7:0] = second_dir_r;
			FIRST_FUNC_LO_OFS:
				for (int p = 0; p < 4; p++) rd_data[p * 4 +: FSEL_W] = first_fsel_r[p * FSEL_W +: FSEL_W];
			FIRST_FUNC_HI_OFS:
				for (int p = 0; p < 4; p++) rd_data[p * 4 +: FSEL_W] = first_fsel_r[(p + 4) * FSEL_W +: FSEL_W];
			SECOND_FUNC_OFS: rd_data[7:0] = second_fsel_r;
			default: rd_ok = 1'b0;
		endcase
	end
endmodule // dual_port_io_pin_mux

// File: sim/pin_mux_sva.sv
`timescale 1ns/1ps
module pin_mux_sva (
	input wire logic MCLK_I,
	input wire logic RSTN_I,
	input wire logic S_AWVALID_I,
	input wire logic S_AWREADY_O,
	input wire logic S_WVALID_I,
	input wire logic S_WREADY_O,
	input wire logic [1:0] S_BRESP_O,
	input wire logic S_BVALID_O,
	input wire logic S_BREADY_I,
	input wire logic S_ARVALID_I,
	input wire logic S_ARREADY_O,
	input wire logic [31:0] S_RDATA_O,
	input wire logic S_RVALID_O,
	input wire logic S_RREADY_I,
	input wire logic [7:0] FIRST_PAD_OE_O,
	input wire logic [7:0] SECOND_PAD_OE_O,
	input wire logic [2:0] LCD_BIAS_SEL_O,
	input wire logic [7:0] SECOND_PERIPH_IN_O
);
	// ----
	// Checks
	// ----
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RSTN_I);
	a_reset_oe_off: assert property ($rose(RSTN_I) |=> FIRST_PAD_OE_O == 8'h00 && SECOND_PAD_OE_O == 8'h00)
		else $error("pin driven right after reset");
	a_write_resp_due: assert property (S_AWVALID_I && S_AWREADY_O && S_WVALID_I && S_WREADY_O |-> ##[1:2] S_BVALID_O)
		else $error("write response late");
	a_bresp_held: assert property (S_BVALID_O && !S_BREADY_I |=> S_BVALID_O && $stable(S_BRESP_O))
		else $error("write response dropped early");
	a_aw_blocked: assert property (S_BVALID_O |-> !S_AWREADY_O)
		else $error("address taken during response");
	a_read_resp_due: assert property (S_ARVALID_I && S_ARREADY_O |=> S_RVALID_O)
		else $error("read response late");
	a_rdata_held: assert property (S_RVALID_O && !S_RREADY_I |=> S_RVALID_O && $stable(S_RDATA_O))
		else $error("read data dropped early");
	a_ar_blocked: assert property (S_RVALID_O |-> !S_ARREADY_O)
		else $error("read taken during response");
	a_pin1_gpio_only: assert property (SECOND_PERIPH_IN_O[1] == 1'b0)
		else $error("second port pin one in peripheral mode");
	a_bias_no_drive: assert property ((LCD_BIAS_SEL_O & $past(LCD_BIAS_SEL_O) & FIRST_PAD_OE_O[2:0]) == 3'h0)
		else $error("bias pin driven");
endmodule // pin_mux_sva
bind dual_port_io_pin_mux pin_mux_sva i_sva (
	.MCLK_I(MCLK_I),
	.RSTN_I(RSTN_I),
	.S_AWVALID_I(S_AWVALID_I),
	.S_AWREADY_O(S_AWREADY_O),
	.S_WVALID_I(S_WVALID_I),
	.S_WREADY_O(S_WREADY_O),
	.S_BRESP_O(S_BRESP_O),
	.S_BVALID_O(S_BVALID_O),
	.S_BREADY_I(S_BREADY_I),
	.S_ARVALID_I(S_ARVALID_I),
	.S_ARREADY_O(S_ARREADY_O),
	.S_RDATA_O(S_RDATA_O),
	.S_RVALID_O(S_RVALID_O),
	.S_RREADY_I(S_RREADY_I),
	.FIRST_PAD_OE_O(FIRST_PAD_OE_O),
	.SECOND_PAD_OE_O(SECOND_PAD_OE_O),
	.LCD_BIAS_SEL_O(LCD_BIAS_SEL_O),
	.SECOND_PERIPH_IN_O(SECOND_PERIPH_IN_O)
);

// File: sim/pad_model.sv
`timescale 1ns/1ps
module pad_model (
	input wire logic clk_i,
	input wire logic [7:0] oe_i,
	input wire logic [7:0] drv_i,
	input wire logic [7:0] ext_en_i,
	input wire logic [7:0] ext_i,
	output logic [7:0] lvl_o
);
	// ----
	// Wire level
	// ----
	logic [7:0] last_r = 8'h00;
	always_ff @(posedge clk_i) begin
		last_r <= lvl_o;
	end
	// No keeper: an undriven pin wanders, never holds its last level
	assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_i) | (~oe_i & ~ext_en_i & ~last_r);
endmodule // pad_model

// File: sim/dual_port_io_pin_mux_tb.sv
`timescale 1ns/1ps
module dual_port_io_pin_mux_tb;
	import pin_mux_pkg::*;
	logic clk = 0, rstn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	logic [7:0] awa = 0, ara = 0, e1v = 0, e2en = 8'hFF, e2v = 0, fo = 0, foe = 0, so = 0, soe = 0;
	logic [31:0] wd = 0, rd;
	logic awr, wrd, bv, arr, rv;
	logic [1:0] br, rr;
	logic [7:0] p1i, p1o, p1oe, p2i, p2o, p2oe, fin, sin, a;
	logic [2:0] bias;
	logic [3:0] cur;
	logic [7:0] lg [8] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h0E, 8'h0E, 8'h7A, 8'h7A};
	int failures = 0, tests_run = 0, cyc = 0, p, c, i;
	always #50 clk = ~clk;
	dual_port_io_pin_mux i_dut (.MCLK_I(clk), .RSTN_I(rstn), .S_AWADDR_I(awa), .S_AWVALID_I(awv),
		.S_AWREADY_O(awr), .S_WDATA_I(wd), .S_WSTRB_I(4'hF), .S_WVALID_I(wv), .S_WREADY_O(wrd),
		.S_BRESP_O(br), .S_BVALID_O(bv), .S_BREADY_I(bre), .S_ARADDR_I(ara), .S_ARVALID_I(arv),
		.S_ARREADY_O(arr), .S_RDATA_O(rd), .S_RRESP_O(rr), .S_RVALID_O(rv), .S_RREADY_I(rre),
		.FIRST_PAD_I(p1i), .FIRST_PAD_O(p1o), .FIRST_PAD_OE_O(p1oe), .SECOND_PAD_I(p2i),
		.SECOND_PAD_O(p2o), .SECOND_PAD_OE_O(p2oe), .LCD_BIAS_SEL_O(bias), .FIRST_PERIPH_OUT_I(fo),
		.FIRST_PERIPH_OE_I(foe), .FIRST_PERIPH_IN_O(fin), .SECOND_PERIPH_OUT_I(so),
		.SECOND_PERIPH_OE_I(soe), .SECOND_PERIPH_IN_O(sin));
	pad_model i_pm1 (.clk_i(clk), .oe_i(p1oe), .drv_i(p1o), .ext_en_i(8'hFF), .ext_i(e1v), .lvl_o(p1i));
	pad_model i_pm2 (.clk_i(clk), .oe_i(p2oe), .drv_i(p2o), .ext_en_i(e2en), .ext_i(e2v), .lvl_o(p2i));
	// ----
	// Tasks
	// ----
	task end_of_test;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			end_of_test();
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task settle;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask
	task wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw;
		ta = 0;
		tw = 0;
		@(posedge clk);
		awa <= ad;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		while (!(ta && tw)) begin
			@(negedge clk);
			if (awv && awr) ta = 1;
			if (wv && wrd) tw = 1;
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end
		// Late ready on purpose so the slave must hold its answer
		@(posedge clk);
		@(posedge clk);
		bre <= 1'b1;
		do @(negedge clk); while (!bv);
		chk(32'(br), 32'(er));
		@(posedge clk);
		bre <= 1'b0;
	endtask
	task rdk(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er);
		logic ta;
		ta = 0;
		@(posedge clk);
		ara <= ad;
		arv <= 1'b1;
		while (!ta) begin
			@(negedge clk);
			ta = arv && arr;
			@(posedge clk);
		end
		arv <= 1'b0;
		@(posedge clk);
		rre <= 1'b1;
		do @(negedge clk); while (!rv);
		chk(rd, e);
		chk(32'(rr), 32'(er));
		@(posedge clk);
		rre <= 1'b0;
	endtask
	// ----
	// Tests
	// ----
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		e2v <= 8'hA5;
		rdk(FIRST_DIR_OFS, 32'hFF, RESP_OKAY);
		rdk(SECOND_DIR_OFS, 32'hFF, RESP_OKAY);
		chk(32'({p1oe, p2oe}), 32'h0);
		rdk(SECOND_LEVELS_OFS, 32'hA5, RESP_OKAY);
		$display("test reset done");
		wr(SECOND_LEVELS_OFS, 32'h3C, RESP_OKAY);
		settle;
		chk(32'(p2oe), 32'h0);
		for (i = 0; i < 8; i++) begin
			a = 8'h01 << i;
			e2en <= ~a;
			wr(SECOND_DIR_OFS, 32'(~a), RESP_OKAY);
			settle;
			chk(32'(p2oe), 32'(a));
			chk(32'(p2o & a), 32'(8'h3C & a));
			rdk(SECOND_LEVELS_OFS, 32'((8'hA5 & ~a) | (8'h3C & a)), RESP_OKAY);
		end
		$display("test direction done");
		so <= 8'hAA;
		soe <= 8'hFF;
		e2en <= 8'h02;
		// Pin one held high outside so a leak into peripheral mode shows
		e2v <= 8'hA7;
		wr(SECOND_DIR_OFS, 32'hFF, RESP_OKAY);
		wr(SECOND_FUNC_OFS, 32'hFF, RESP_OKAY);
		rdk(SECOND_FUNC_OFS, 32'hFD, RESP_OKAY);
		settle;
		chk(32'(p2oe), 32'hFD);
		chk(32'(p2o & 8'hFD), 32'hA8);
		chk(32'(sin), 32'hA8);
		rdk(SECOND_LEVELS_OFS, 32'hAA, RESP_OKAY);
		$display("test second functions done");
		fo <= 8'h55;
		foe <= 8'hFF;
		e1v <= 8'h30;
		for (p = 0; p < 8; p++) begin
			cur = 0;
			a = (p < 4) ? FIRST_FUNC_LO_OFS : FIRST_FUNC_HI_OFS;
			for (c = 1; c < 7; c++) begin
				if (lg[p][c]) cur = 4'(c);
				wr(a, 32'(c) << (4 * (p % 4)), RESP_OKAY);
				settle;
				rdk(a, 32'(cur) << (4 * (p % 4)), RESP_OKAY);
				chk(32'(p1oe[p]), 32'(cur != 0 && cur != 2 && p > 2));
				chk(32'(fin[p]), 32'(p > 2 && (cur == 2 || p % 2 == 0)));
				if (p > 2) chk(32'(p1o[p]), 32'(p % 2 == 0));
				chk(32'(bias), (p < 3 && cur == 1) ? 32'h1 << p : 32'h0);
			end
			wr(a, 32'h0, RESP_OKAY);
		end
		$display("test first functions done");
		wr(FIRST_LEVELS_OFS, 32'h96, RESP_OKAY);
		wr(FIRST_DIR_OFS, 32'hF0, RESP_OKAY);
		settle;
		chk(32'(p1oe), 32'h0F);
		chk(32'(p1o & 8'h0F), 32'h06);
		rdk(FIRST_LEVELS_OFS, 32'h36, RESP_OKAY);
		$display("test first port done");
		wr(8'h1C, 32'hFF, RESP_SLVERR);
		rdk(8'h1C, 32'h0, RESP_SLVERR);
		$display("test unmapped done");
		end_of_test();
	end
endmodule // dual_port_io_pin_mux_tb
